// *** design/unbl_map.svh ***
`ifndef UNBL_MAP_SVH
`define UNBL_MAP_SVH
// Register word indices on the register port
`define UNBL_CTRL3_IDX 8'h06
`define UNBL_DATA_IDX 8'h07
`define UNBL_IRQ_STAT_IDX 8'h10
`define UNBL_IRQ_CLR_IDX 8'h11
`define UNBL_IRQ_EN_IDX 8'h12
`define UNBL_LINE_CTRL_IDX 8'h13
// Control register three fields
`define UNBL_CTRL3_RESET 8'h00
`define UNBL_RX9_BIT 7
`define UNBL_TX9_BIT 6
`define UNBL_DIR_BIT 5
`define UNBL_INV_BIT 4
`define UNBL_OVR_EN_BIT 3
`define UNBL_NOISE_EN_BIT 2
`define UNBL_FRAME_EN_BIT 1
`define UNBL_PARITY_EN_BIT 0
`define UNBL_WR_MASK 8'h7F
`define UNBL_ERR_SRC_CNT 3
// Reset and padding values
`define UNBL_BYTE_RESET 8'h00
`define UNBL_FRAME_RESET 9'h000
`define UNBL_EV_RESET 2'h0
`define UNBL_PAD_ZERO 6'h00
// Frame layout
`define UNBL_BYTE_MSB 7
`define UNBL_NINTH_POS 8
// Line control fields (own register)
`define UNBL_LC_NINE_BIT 0
`define UNBL_LC_LOOP_BIT 1
`define UNBL_LC_SRC_BIT 2
`define UNBL_LC_MASK 8'h07
// Event status layout
`define UNBL_EV_WIDTH 2
`define UNBL_EV_OVR 0
`define UNBL_EV_ERR 1
`endif

// *** design/unbl_pkg.sv ***
package unbl_pkg;
  typedef logic [7:0] unbl_byte_t;
  typedef logic [8:0] unbl_frame_t;
endpackage

// *** design/unbl_ctrl.sv ***
// Contract
// - In 9-bit mode, bit 7 shows the ninth received bit above the byte.
// - In 9-bit mode, data write loads ninth bit 6 plus byte into shifter.
// - Ninth transmit bit persists across data buffer writes.
// - In single-wire mode, bit 5 sets transmit pin direction, 1 output.
// - Bit 4 inverts every transmit output level when set.
// - Control register three at offset 6, all bits reset to zero.
// - Bit 3 gates overrun flag onto interrupt request.
// - Bits 2,1,0 gate noise, framing and parity flag interrupt requests.
`timescale 1ns/1ns
`default_nettype none
`include "unbl_map.svh"
module unbl_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Receiver side
  input wire logic rx_load_i,
  input wire logic [8:0] rx_frame_i,
  input wire logic overrun_flag_i,
  input wire logic noise_flag_i,
  input wire logic framing_fault_flag_i,
  input wire logic parity_fault_flag_i,
  output logic data_read_o,
  // Transmitter side
  output logic tx_load_o,
  output logic [8:0] tx_frame_o,
  input wire logic tx_line_i,
  // Transmit pin
  output logic txd_o,
  output logic txd_oe_o,
  // Interrupt
  output logic irq_o
);

  logic [7:0] ctrl3_reg, ctrl3_next;
  logic [7:0] rxbuf_reg, rxbuf_next;
  logic [7:0] line_reg, line_next;
  logic [`UNBL_EV_WIDTH-1:0] stat_reg, stat_next;
  logic [`UNBL_EV_WIDTH-1:0] en_reg, en_next;
  logic [7:0] rdata_reg, rdata_next;
  logic tx_load_reg, tx_load_next;
  unbl_pkg::unbl_frame_t tx_frame_reg, tx_frame_next;
  logic nine_bit, single_wire, ovr_req, err_req;
  logic [`UNBL_EV_WIDTH-1:0] ev_raw, ev_prev_reg, ev_prev_next, ev_rise;
  logic [`UNBL_ERR_SRC_CNT-1:0] err_flag, err_en, err_gated;

  // Register address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction

  // Mode decode from line control
  assign nine_bit = line_reg[`UNBL_LC_NINE_BIT];
  assign single_wire = line_reg[`UNBL_LC_LOOP_BIT] & line_reg[`UNBL_LC_SRC_BIT];

  // Overrun request gated by its enable
  // overrun enable gate
  assign ovr_req = ctrl3_reg[`UNBL_OVR_EN_BIT] & overrun_flag_i;

  // Error flags in enable bit order: noise, framing, parity
  assign err_flag = {noise_flag_i, framing_fault_flag_i, parity_fault_flag_i};
  assign err_en = ctrl3_reg[`UNBL_NOISE_EN_BIT:`UNBL_PARITY_EN_BIT];

  // One gate per error source
  // error enable gates
  genvar gi;
  generate
    for (gi = 0; gi < `UNBL_ERR_SRC_CNT; gi++) begin : g_err_gate
      assign err_gated[gi] = err_en[gi] & err_flag[gi];
    end
  endgenerate

  // Any enabled error raises the shared error request
  assign err_req = |err_gated;
  assign ev_raw = {err_req, ovr_req};
  // Only a new request sets status, so a held flag counts once
  assign ev_rise = ev_raw & ~ev_prev_reg;

  // Control register three and receive buffer next state
  always_comb begin
    ctrl3_next = ctrl3_reg;
    rxbuf_next = rxbuf_reg;
    // receive ninth bit zero in 8-bit mode
    if (rx_load_i) begin
      rxbuf_next = rx_frame_i[`UNBL_BYTE_MSB:0];
      ctrl3_next[`UNBL_RX9_BIT] = nine_bit & rx_frame_i[`UNBL_NINTH_POS];
    end
    // Receive-only bit 7 stays out of the write mask
    if (wr_i && hit(addr_i, `UNBL_CTRL3_IDX)) begin
      ctrl3_next = (ctrl3_next & ~`UNBL_WR_MASK) | (wdata_i & `UNBL_WR_MASK);
    end
  end

  // Transmit load next state
  // load nine-bit frame on data write
  // ninth bit dropped in 8-bit mode
  always_comb begin
    tx_load_next = 1'b0;
    tx_frame_next = tx_frame_reg;
    if (wr_i && hit(addr_i, `UNBL_DATA_IDX)) begin
      tx_load_next = 1'b1;
      tx_frame_next = {nine_bit & ctrl3_reg[`UNBL_TX9_BIT], wdata_i};
    end
  end

  // Line control next state
  always_comb begin
    line_next = line_reg;
    if (wr_i && hit(addr_i, `UNBL_LINE_CTRL_IDX)) begin
      line_next = wdata_i & `UNBL_LC_MASK;
    end
  end

  // Interrupt enable, status and edge detector next state
  always_comb begin
    en_next = en_reg;
    stat_next = stat_reg;
    ev_prev_next = ev_raw;
    if (wr_i && hit(addr_i, `UNBL_IRQ_EN_IDX)) begin
      en_next = wdata_i[`UNBL_EV_WIDTH-1:0];
    end
    if (wr_i && hit(addr_i, `UNBL_IRQ_CLR_IDX)) begin
      stat_next = stat_next & ~wdata_i[`UNBL_EV_WIDTH-1:0];
    end
    // Set wins over clear in the same cycle
    stat_next = stat_next | ev_rise;
  end

  // Read data, one cycle after strobe, zero otherwise
  always_comb begin
    rdata_next = `UNBL_BYTE_RESET;
    if (rd_i) begin
      if (hit(addr_i, `UNBL_CTRL3_IDX)) begin
        rdata_next = ctrl3_reg;
      end else if (hit(addr_i, `UNBL_DATA_IDX)) begin
        rdata_next = rxbuf_reg;
      end else if (hit(addr_i, `UNBL_IRQ_STAT_IDX)) begin
        rdata_next = {`UNBL_PAD_ZERO, stat_reg};
      end else if (hit(addr_i, `UNBL_IRQ_EN_IDX)) begin
        rdata_next = {`UNBL_PAD_ZERO, en_reg};
      end else if (hit(addr_i, `UNBL_LINE_CTRL_IDX)) begin
        rdata_next = line_reg;
      end
    end
  end

  // Control register three and receive buffer
  // reset to zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl3_reg <= `UNBL_CTRL3_RESET;
      rxbuf_reg <= `UNBL_BYTE_RESET;
    end else begin
      ctrl3_reg <= ctrl3_next;
      rxbuf_reg <= rxbuf_next;
    end
  end

  // Transmit load pulse and frame
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_load_reg <= 1'b0;
      tx_frame_reg <= `UNBL_FRAME_RESET;
    end else begin
      tx_load_reg <= tx_load_next;
      tx_frame_reg <= tx_frame_next;
    end
  end

  // Line control
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      line_reg <= `UNBL_BYTE_RESET;
    end else begin
      line_reg <= line_next;
    end
  end

  // Interrupt enable, status and edge detector
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      en_reg <= `UNBL_EV_RESET;
      stat_reg <= `UNBL_EV_RESET;
      ev_prev_reg <= `UNBL_EV_RESET;
    end else begin
      en_reg <= en_next;
      stat_reg <= stat_next;
      ev_prev_reg <= ev_prev_next;
    end
  end

  // Read data register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_reg <= `UNBL_BYTE_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs
  assign rdata_o = rdata_reg;
  assign tx_load_o = tx_load_reg;
  assign tx_frame_o = tx_frame_reg;
  // buffer read marks flag sequence done
  assign data_read_o = rd_i & hit(addr_i, `UNBL_DATA_IDX);
  assign txd_o = tx_line_i ^ ctrl3_reg[`UNBL_INV_BIT];
  assign txd_oe_o = single_wire ? ctrl3_reg[`UNBL_DIR_BIT] : 1'b1;
  // Level interrupt while any enabled status bit is set
  assign irq_o = |(stat_reg & en_reg);

endmodule
`default_nettype wire

// *** tb/unbl_peer.sv ***
`timescale 1ns/1ns
`default_nettype none
module unbl_peer (
  // Line side
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic tx_load_i,
  input wire logic [8:0] tx_frame_i,
  // Echo into receiver
  output logic rx_load_o,
  output logic [8:0] rx_frame_o
);
  // Remote node echoes every frame one cycle later
  always_ff @(posedge clk_i) begin
    rx_load_o <= tx_load_i && !srst_i;
    if (tx_load_i) rx_frame_o <= tx_frame_i;
  end
endmodule
`default_nettype wire

// *** tb/unbl_ctrl_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module unbl_ctrl_monitor (
  // Watched ports
  input wire logic clk_i, srst_i, wr_i, rd_i, tx_load_o, data_read_o,
  input wire logic txd_o, tx_line_i, txd_oe_o, irq_o,
  input wire logic [7:0] addr_i, wdata_i, rdata_o,
  input wire logic [8:0] tx_frame_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire logic wd = wr_i && addr_i == 8'h07;
  property p_load; wd |=> tx_load_o && tx_frame_o[7:0] == $past(wdata_i); endproperty
  a_load: assert property (p_load) else $error("no load");
  property p_noload; !wd |=> !tx_load_o; endproperty
  a_noload: assert property (p_noload) else $error("stray load");
  property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stray data");
  property p_keep; wr_i && addr_i == 8'h06 ##2 rd_i && addr_i == 8'h06
    |=> (rdata_o & 8'h7F) == ($past(wdata_i, 3) & 8'h7F); endproperty
  a_keep: assert property (p_keep) else $error("ctrl lost");
  property p_inv; !$past(srst_i) && !$past(wr_i) |-> $stable(txd_o ^ tx_line_i); endproperty
  a_inv: assert property (p_inv) else $error("polarity moved");
  property p_rst; $past(srst_i) |-> txd_oe_o && !irq_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_dr; rd_i && addr_i == 8'h07 |-> data_read_o; endproperty
  a_dr: assert property (p_dr) else $error("no data read");
  property p_dronly; data_read_o |-> rd_i && addr_i == 8'h07; endproperty
  a_dronly: assert property (p_dronly) else $error("stray data read");
  c_irq: cover property (irq_o);
  c_in: cover property (!txd_oe_o);
  c_nine: cover property (tx_load_o && tx_frame_o[8]);
endmodule
bind unbl_ctrl unbl_ctrl_monitor u_mon (.clk_i, .srst_i, .wr_i, .rd_i, .tx_load_o, .data_read_o,
  .txd_o, .tx_line_i, .txd_oe_o, .irq_o, .addr_i, .wdata_i, .rdata_o, .tx_frame_o);
`default_nettype wire

// *** tb/unbl_ctrl_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module unbl_ctrl_tb;
  logic clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, tx_line_i = 1'b0;
  logic ovr = 1'b0, nse = 1'b0, frm = 1'b0, par = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic rx_load, data_read_o, tx_load_o, txd_o, txd_oe_o, irq_o;
  logic [8:0] rx_frame, tx_frame_o;
  int mismatches = 0, tests_run = 0;
  unbl_ctrl dut (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_load_i(rx_load),
    .rx_frame_i(rx_frame), .overrun_flag_i(ovr), .noise_flag_i(nse), .framing_fault_flag_i(frm),
    .parity_fault_flag_i(par), .data_read_o, .tx_load_o, .tx_frame_o, .tx_line_i, .txd_o,
    .txd_oe_o, .irq_o);
  unbl_peer peer (.clk_i, .srst_i, .tx_load_i(tx_load_o), .tx_frame_i(tx_frame_o),
    .rx_load_o(rx_load), .rx_frame_o(rx_frame));
  initial forever #25 clk_i = ~clk_i;
  task automatic chk(string n, logic [8:0] e, logic [8:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus cycles, one strobe cycle each
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", {1'b0, e}, {1'b0, rdata_o});
  endtask
  task automatic t_frames;
    rd(8'h06, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h13, 8'h01);
    wr(8'h06, 8'h40);
    wr(8'h07, 8'hAA);
    chk("frame", 9'h1AA, tx_frame_o);
    wr(8'h07, 8'h55);
    chk("frame", 9'h155, tx_frame_o);
    rd(8'h06, 8'hC0);
    rd(8'h07, 8'h55);
    wr(8'h13, 8'h00);
    wr(8'h07, 8'h33);
    chk("frame", 9'h033, tx_frame_o);
  endtask
  task automatic t_pin;
    wr(8'h06, 8'h10);
    chk("txd", 9'h001, {8'h00, txd_o});
    wr(8'h13, 8'h06);
    wr(8'h06, 8'h00);
    chk("oe", 9'h000, {8'h00, txd_oe_o});
    chk("txd", 9'h000, {8'h00, txd_o});
    wr(8'h06, 8'h20);
    chk("oe", 9'h001, {8'h00, txd_oe_o});
    rd(8'h06, 8'h20);
  endtask
  task automatic t_irq;
    wr(8'h12, 8'h03);
    wr(8'h06, 8'h08);
    @(posedge clk_i);
    ovr <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk("irq", 9'h001, {8'h00, irq_o});
    ovr <= 1'b0;
    wr(8'h11, 8'h03);
    wr(8'h06, 8'h00);
    nse <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk("irq", 9'h000, {8'h00, irq_o});
    wr(8'h06, 8'h04);
    repeat (3) @(posedge clk_i);
    #1 chk("irq", 9'h001, {8'h00, irq_o});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    t_frames;
    t_pin;
    t_irq;
    give_verdict;
  end
  // Watchdog
  initial begin
    #100000;
    mismatches++;
    give_verdict;
  end
endmodule
`default_nettype wire
